// ---- ufc_defines.svh ----
`ifndef UFC_DEFINES_SVH
`define UFC_DEFINES_SVH
// ****************************************
// Register map
// ****************************************
`define UFC_REG_CTRL     4'h0
`define UFC_REG_STAT     4'h4
`define UFC_REG_RXSTS    4'h8
`define UFC_REG_RXPTR    4'hc
`define UFC_CTRL_RECEIVER_ENABLE_BIT    0
`define UFC_CTRL_FLUSH   1
`define UFC_STAT_TXE     0
`define UFC_STAT_STOPPED 1
`define UFC_STAT_FLUSH   2
// ****************************************
// Receive status word fields
// ****************************************
`define UFC_RS_ES        15
`define UFC_RS_RUNT      11
`define UFC_RS_LONG      7
`define UFC_RS_LATE      6
`define UFC_RS_TYPE      5
`define UFC_RS_WDOG      4
`define UFC_RS_MIIERR    3
`define UFC_RS_DRIB      2
`define UFC_RS_CRC       1
`define UFC_RS_RSVD0     0
`define UFC_RS_LEN_LO    16
`define UFC_TYPE_LIMIT   16'h05dc
`define UFC_RUNT_BYTES   14'h000e
`define UFC_WDOG_BYTES   14'h0800
`define UFC_DRIB_MII     3'h4
`define UFC_DRIB_10M     3'h3
// ****************************************
// Transmit command words
// ****************************************
`define UFC_CA_SIZE_HI   10
`define UFC_CA_LAST      12
`define UFC_CA_FIRST     13
`define UFC_CA_OFF_LO    16
`define UFC_CA_OFF_HI    17
`define UFC_CB_FLEN_HI   10
`define UFC_CB_CK        14
`define UFC_TXQ_AW       11
`define UFC_TXQ_DEPTH    12'h800
`define UFC_RXQ_AW       13
`endif

// ---- ufc_pkg.sv ----
package ufc_pkg;
  typedef enum logic [1:0]
  {
    TX_CMDA = 2'b00,
    TX_CMDB = 2'b01,
    TX_DATA = 2'b10
  } ufc_txst_e;
  typedef logic [31:0] ufc_word_t;
endpackage

// ---- ufc_txq_if.sv ----
interface ufc_txq_if;
  logic                 wr_valid;
  logic                 wr_ready;
  ufc_pkg::ufc_word_t   wr_data;
  logic                 commit;
  logic                 rewind;
  logic                 rd_valid;
  logic                 rd_ready;
  ufc_pkg::ufc_word_t   rd_data;
  modport fifo (input wr_valid, wr_data, commit, rewind, rd_ready,
                output wr_ready, rd_valid, rd_data);
  modport user (output wr_valid, wr_data, commit, rewind, rd_ready,
                input wr_ready, rd_valid, rd_data);
endinterface

// ---- ufc_txq.sv ----
`include "ufc_defines.svh"
module ufc_txq
(
  input  wire logic  clk,
  input  wire logic  rstn,
  ufc_txq_if.fifo    q
);
  // 8 kB as 2048 words; pointers carry one wrap bit
  ufc_pkg::ufc_word_t       mem_r [0:(1<<`UFC_TXQ_AW)-1];
  logic [`UFC_TXQ_AW:0]     wr_r;
  logic [`UFC_TXQ_AW:0]     hd_r;
  logic [`UFC_TXQ_AW:0]     rd_r;
  logic [`UFC_TXQ_AW:0]     used;
  wire                      wr_go = q.wr_valid & q.wr_ready;
  wire                      rd_go = q.rd_valid & q.rd_ready;

  assign used       = wr_r - rd_r;
  assign q.wr_ready = (used != `UFC_TXQ_DEPTH) & ~q.rewind;
  // Only committed packets are visible to the reader
  assign q.rd_valid = rd_r != hd_r;
  assign q.rd_data  = mem_r[rd_r[`UFC_TXQ_AW-1:0]];

  always_ff @(posedge clk)
  begin
    if (wr_go)
      mem_r[wr_r[`UFC_TXQ_AW-1:0]] <= q.wr_data;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_r <= '0;
      hd_r <= '0;
      rd_r <= '0;
    end
    else
    begin
      if (q.rewind)
        wr_r <= hd_r;
      else if (wr_go)
        wr_r <= wr_r + 1'b1;
      if (q.commit & ~q.rewind)
        hd_r <= wr_go ? wr_r + 1'b1 : wr_r;
      if (rd_go)
        rd_r <= rd_r + 1'b1;
    end
  end

  property p_rewind;
    @(posedge clk) disable iff (!rstn) q.rewind |=> wr_r == $past(hd_r);
  endproperty
  a_rewind: assert property (p_rewind) else $error("rewind missed");
endmodule

// ---- ufc_rxsts.sv ----
`include "ufc_defines.svh"
module ufc_rxsts
(
  input  wire logic         late_col,
  input  wire logic [15:0]  len_type,
  input  wire logic [13:0]  frame_bytes,
  input  wire logic         rx_er_seen,
  input  wire logic [2:0]   dribble_bits,
  input  wire logic         mode_10m,
  input  wire logic         crc_bad,
  input  wire logic         runt,
  input  wire logic         too_long,
  output logic [31:0]       status
);
  wire wdog  = frame_bytes > `UFC_WDOG_BYTES;
  wire drib  = ~late_col & (mode_10m ? dribble_bits >= `UFC_DRIB_10M
                                     : dribble_bits == `UFC_DRIB_MII);
  // CRC flag is meaningless for these frames, so it is held low
  wire crcok = ~(runt | late_col | wdog);
  wire crc   = crcok & (crc_bad | rx_er_seen);
  wire ftype = (frame_bytes >= `UFC_RUNT_BYTES) & (len_type > `UFC_TYPE_LIMIT);

  always_comb
  begin
    status                                 = '0;
    status[`UFC_RS_LEN_LO+13:`UFC_RS_LEN_LO] = frame_bytes;
    status[`UFC_RS_RUNT]                   = runt;
    status[`UFC_RS_LONG]                   = too_long;
    status[`UFC_RS_LATE]                   = late_col;
    status[`UFC_RS_TYPE]                   = ftype;
    status[`UFC_RS_WDOG]                   = wdog;
    status[`UFC_RS_MIIERR]                 = rx_er_seen;
    status[`UFC_RS_DRIB]                   = drib;
    status[`UFC_RS_CRC]                    = crc;
    status[`UFC_RS_RSVD0]                  = 1'b0;
    status[`UFC_RS_ES]                     = runt | too_long | late_col | crc;
  end
endmodule

// ---- ufc_top.sv ----
// Local design decisions: the address map and the plain strobed port.
`include "ufc_defines.svh"
module ufc_top
(
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [3:0]   reg_addr,
  input  wire logic [31:0]  reg_wdata,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  output logic [31:0]       reg_rdata,
  input  wire logic         usb_wvalid,
  input  wire logic [31:0]  usb_wdata,
  output logic              usb_wready,
  input  wire logic         usb_commit,
  input  wire logic         usb_rewind,
  output logic              tx_valid,
  output logic [31:0]       tx_data,
  output logic              tx_last,
  input  wire logic         tx_ready,
  input  wire logic         rx_done,
  input  wire logic         rx_late_col,
  input  wire logic [15:0]  rx_len_type,
  input  wire logic [13:0]  rx_frame_bytes,
  input  wire logic         rx_er_seen,
  input  wire logic [2:0]   rx_dribble_bits,
  input  wire logic         rx_mode_10m,
  input  wire logic         rx_crc_bad,
  input  wire logic         rx_runt,
  input  wire logic         rx_too_long,
  input  wire logic         rx_busy,
  input  wire logic         rx_wr_adv,
  input  wire logic         rx_rd_adv,
  output logic              receiver_enable_bit,
  output logic              receiver_stopped_event,
  output logic              rx_frame_ok,
  output logic [31:0]       rx_status_word
);
  // ****************************************
  // Register bus
  // ****************************************
  logic                     receiver_enable_bit_r;
  logic                     flush_r;
  logic                     txe_r;
  logic                     txe_nxt;
  logic                     stop_pend_r;
  logic                     stopped_r;
  logic                     stop_pulse_r;
  logic [31:0]              rdata_r;
  logic [31:0]              rdata_nxt;
  logic [31:0]              rxsts_r;
  logic [31:0]              rxsts_nxt;
  logic [`UFC_RXQ_AW-1:0]   rx_wp_r;
  logic [`UFC_RXQ_AW-1:0]   rx_rp_r;

  wire wr_ctrl  = reg_wr & (reg_addr == `UFC_REG_CTRL);
  wire wr_stat  = reg_wr & (reg_addr == `UFC_REG_STAT);
  wire txe_clr  = wr_stat & reg_wdata[`UFC_STAT_TXE];
  wire flush_go = flush_r;

  always_comb
  begin
    rdata_nxt = '0;
    case (reg_addr)
      `UFC_REG_CTRL:
      begin
        rdata_nxt[`UFC_CTRL_RECEIVER_ENABLE_BIT]  = receiver_enable_bit_r;
        rdata_nxt[`UFC_CTRL_FLUSH] = flush_r;
      end
      `UFC_REG_STAT:
      begin
        rdata_nxt[`UFC_STAT_TXE]     = txe_r;
        rdata_nxt[`UFC_STAT_STOPPED] = stopped_r;
        rdata_nxt[`UFC_STAT_FLUSH]   = flush_r;
      end
      `UFC_REG_RXSTS: rdata_nxt = rxsts_r;
      `UFC_REG_RXPTR: rdata_nxt = {3'h0, rx_rp_r, 3'h0, rx_wp_r};
      default:        rdata_nxt = '0;
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rdata_r <= '0;
    else
      rdata_r <= reg_rd ? rdata_nxt : '0;
  end
  assign reg_rdata = rdata_r;

  // ****************************************
  // Receiver stop and FIFO flush
  // ****************************************
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      receiver_enable_bit_r  <= 1'b0;
      flush_r <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
        receiver_enable_bit_r <= reg_wdata[`UFC_CTRL_RECEIVER_ENABLE_BIT];
      // Flush finishes in one cycle, then the bit drops by itself
      if (wr_ctrl & reg_wdata[`UFC_CTRL_FLUSH])
        flush_r <= 1'b1;
      else
        flush_r <= 1'b0;
    end
  end
  assign receiver_enable_bit = receiver_enable_bit_r;

  // A frame in flight is allowed to finish before the halt is reported
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      stop_pend_r  <= 1'b0;
      stopped_r    <= 1'b1;
      stop_pulse_r <= 1'b0;
    end
    else
    begin
      stop_pulse_r <= stop_pend_r & ~rx_busy & ~receiver_enable_bit_r;
      if (receiver_enable_bit_r)
      begin
        stop_pend_r <= 1'b0;
        stopped_r   <= 1'b0;
      end
      else if (~stopped_r & ~stop_pend_r)
        stop_pend_r <= 1'b1;
      else if (stop_pend_r & ~rx_busy)
      begin
        stop_pend_r <= 1'b0;
        stopped_r   <= 1'b1;
      end
    end
  end
  assign receiver_stopped_event = stop_pulse_r;

  // Only pointers are modelled; frame storage of the receive side lives elsewhere
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rx_wp_r <= '0;
      rx_rp_r <= '0;
    end
    else if (flush_go)
    begin
      rx_wp_r <= '0;
      rx_rp_r <= '0;
    end
    else
    begin
      if (rx_wr_adv)
        rx_wp_r <= rx_wp_r + 1'b1;
      if (rx_rd_adv)
        rx_rp_r <= rx_rp_r + 1'b1;
    end
  end

  // ****************************************
  // Receive status word
  // ****************************************
  ufc_rxsts u_rxsts
  (
    .late_col     (rx_late_col),
    .len_type     (rx_len_type),
    .frame_bytes  (rx_frame_bytes),
    .rx_er_seen   (rx_er_seen),
    .dribble_bits (rx_dribble_bits),
    .mode_10m     (rx_mode_10m),
    .crc_bad      (rx_crc_bad),
    .runt         (rx_runt),
    .too_long     (rx_too_long),
    .status       (rxsts_nxt)
  );

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rxsts_r     <= '0;
      rx_frame_ok <= 1'b0;
    end
    else if (rx_done)
    begin
      rxsts_r     <= rxsts_nxt;
      rx_frame_ok <= ~rxsts_nxt[`UFC_RS_CRC];
    end
  end
  assign rx_status_word = rxsts_r;

  // ****************************************
  // Transmit FIFO and command parser
  // ****************************************
  ufc_txq_if q ();
  ufc_txq u_txq
  (
    .clk  (clk),
    .rstn (rstn),
    .q    (q.fifo)
  );
  assign q.wr_valid = usb_wvalid;
  assign q.wr_data  = usb_wdata;
  assign q.commit   = usb_commit;
  assign q.rewind   = usb_rewind;
  assign usb_wready = q.wr_ready;

  ufc_pkg::ufc_txst_e       st_r;
  ufc_pkg::ufc_word_t       cmda_r;
  ufc_pkg::ufc_word_t       cmdb_ref_r;
  logic [13:0]              acc_r;
  logic [10:0]              left_r;

  wire        take    = q.rd_valid & q.rd_ready;
  wire [10:0] bsize   = cmda_r[`UFC_CA_SIZE_HI:0];
  wire [1:0]  off     = cmda_r[`UFC_CA_OFF_HI:`UFC_CA_OFF_LO];
  wire [12:0] span    = 13'(bsize) + 13'(off) + 13'h3;
  wire [10:0] words   = span[12:2];
  wire        first   = cmda_r[`UFC_CA_FIRST];
  wire        lastseg = cmda_r[`UFC_CA_LAST];
  wire [31:0] ck_mask = ~(32'h1 << `UFC_CB_CK);
  wire        b_diff  = |((q.rd_data ^ cmdb_ref_r) & ck_mask);
  wire [13:0] acc_sum = first ? 14'(bsize) : acc_r + 14'(bsize);
  wire [13:0] flen    = 14'(q.rd_data[`UFC_CB_FLEN_HI:0]);
  wire [13:0] flen_r  = 14'(cmdb_ref_r[`UFC_CB_FLEN_HI:0]);
  wire        b_err   = take & (st_r == ufc_pkg::TX_CMDB) & ~first & b_diff;
  wire        buf_end = (st_r == ufc_pkg::TX_DATA) & take & (left_r == 11'h1);
  wire        empty_b = take & (st_r == ufc_pkg::TX_CMDB) & (words == 11'h0);
  wire        chk_len = (buf_end | empty_b) & lastseg;
  // An empty buffer ends in command B, before the running total is stored
  wire [13:0] acc_now = empty_b ? acc_sum : acc_r;
  wire        l_err   = chk_len & (acc_now != (empty_b & first ? flen : flen_r));

  assign q.rd_ready = (st_r != ufc_pkg::TX_DATA) | tx_ready;
  assign tx_valid   = (st_r == ufc_pkg::TX_DATA) & q.rd_valid;
  assign tx_data    = q.rd_data;
  assign tx_last    = tx_valid & lastseg & (left_r == 11'h1);

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_r       <= ufc_pkg::TX_CMDA;
      cmda_r     <= '0;
      cmdb_ref_r <= '0;
      acc_r      <= '0;
      left_r     <= '0;
    end
    else if (take)
    begin
      case (st_r)
        ufc_pkg::TX_CMDA:
        begin
          cmda_r <= q.rd_data;
          st_r   <= ufc_pkg::TX_CMDB;
        end
        ufc_pkg::TX_CMDB:
        begin
          if (first)
            cmdb_ref_r <= q.rd_data;
          acc_r  <= acc_sum;
          left_r <= words;
          st_r   <= (words == 11'h0) ? ufc_pkg::TX_CMDA : ufc_pkg::TX_DATA;
        end
        ufc_pkg::TX_DATA:
        begin
          left_r <= left_r - 11'h1;
          if (left_r == 11'h1)
            st_r <= ufc_pkg::TX_CMDA;
        end
        default: st_r <= ufc_pkg::TX_CMDA;
      endcase
    end
  end

  // Set beats clear when both land in one cycle
  assign txe_nxt = (b_err | l_err) ? 1'b1 : (txe_clr ? 1'b0 : txe_r);

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      txe_r <= 1'b0;
    else
      txe_r <= txe_nxt;
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_flush_ptr;
    @(posedge clk) disable iff (!rstn) flush_r |=> (rx_wp_r == '0) && (rx_rp_r == '0);
  endproperty
  a_flush_ptr: assert property (p_flush_ptr) else $error("flush kept ptrs");
  property p_flush_clr;
    @(posedge clk) disable iff (!rstn)
    (wr_ctrl && reg_wdata[`UFC_CTRL_FLUSH]) |=> flush_r ##1 !flush_r;
  endproperty
  a_flush_clr: assert property (p_flush_clr) else $error("flush not self clr");
  property p_stop_once;
    @(posedge clk) disable iff (!rstn) receiver_stopped_event |=> !receiver_stopped_event;
  endproperty
  a_stop_once: assert property (p_stop_once) else $error("stop pulse repeated");
  property p_stop_idle;
    @(posedge clk) disable iff (!rstn) receiver_stopped_event |-> $past(!receiver_enable_bit_r && !rx_busy);
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop while busy");
  property p_txe_sticky;
    @(posedge clk) disable iff (!rstn) (txe_r && !txe_clr) |=> txe_r;
  endproperty
  a_txe_sticky: assert property (p_txe_sticky) else $error("txe dropped");
  property p_txe_b;
    @(posedge clk) disable iff (!rstn) b_err |=> txe_r;
  endproperty
  a_txe_b: assert property (p_txe_b) else $error("cmd b mismatch lost");
  property p_txe_len;
    @(posedge clk) disable iff (!rstn) l_err |=> txe_r;
  endproperty
  a_txe_len: assert property (p_txe_len) else $error("length mismatch lost");
  property p_es;
    @(posedge clk) disable iff (!rstn)
    rx_done |=> rxsts_r[`UFC_RS_ES] == (rxsts_r[`UFC_RS_RUNT] | rxsts_r[`UFC_RS_LONG]
                | rxsts_r[`UFC_RS_LATE] | rxsts_r[`UFC_RS_CRC]);
  endproperty
  a_es: assert property (p_es) else $error("summary bit wrong");
  property p_drib_late;
    @(posedge clk) disable iff (!rstn)
    (rx_done && rx_late_col) |=> rxsts_r[`UFC_RS_LATE] && !rxsts_r[`UFC_RS_DRIB];
  endproperty
  a_drib_late: assert property (p_drib_late) else $error("dribble with late");
  property p_crc_inv;
    @(posedge clk) disable iff (!rstn)
    (rx_done && rx_runt) |=> !rxsts_r[`UFC_RS_CRC] && !rxsts_r[`UFC_RS_RSVD0];
  endproperty
  a_crc_inv: assert property (p_crc_inv) else $error("crc on runt");
  property p_rxer;
    @(posedge clk) disable iff (!rstn)
    (rx_done && rx_er_seen) |=> rxsts_r[`UFC_RS_MIIERR] && (rx_frame_ok != rxsts_r[`UFC_RS_CRC]);
  endproperty
  a_rxer: assert property (p_rxer) else $error("rx error lost");
endmodule

// ---- ufc_link_sink.sv ----
// ****************************************
// Link side model: takes transmit words
// ****************************************
module ufc_link_sink
(
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         tx_valid,
  input  wire logic [31:0]  tx_data,
  input  wire logic         tx_last,
  input  wire logic         slow,
  output logic              tx_ready,
  output logic [15:0]       cnt,
  output logic [15:0]       nlast,
  output logic [31:0]       last_d,
  output logic              last_l
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ph_r;
  // Slow mode drops ready every other cycle to stall the reader
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ph_r     <= 1'b0;
      tx_ready <= 1'b0;
      cnt      <= 16'h0000;
      nlast    <= 16'h0000;
      last_d   <= 32'h0000_0000;
      last_l   <= 1'b0;
    end
    else
    begin
      ph_r     <= !ph_r;
      tx_ready <= !slow || ph_r;
      if (tx_valid && tx_ready)
      begin
        cnt    <= cnt + 16'h0001;
        nlast  <= nlast + {15'h0000, tx_last};
        last_d <= tx_data;
        last_l <= tx_last;
      end
    end
  end
endmodule

// ---- tb_top.sv ----
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rstn, reg_wr, reg_rd, usb_wvalid, usb_commit, usb_rewind, slow;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, usb_wdata, tx_data, rx_status_word, last_d;
  logic        usb_wready, tx_valid, tx_last, tx_ready, last_l, rx_done, rx_late_col;
  logic        rx_er_seen, rx_mode_10m, rx_crc_bad, rx_runt, rx_too_long, rx_busy;
  logic        rx_wr_adv, rx_rd_adv, receiver_enable_bit, receiver_stopped_event, rx_frame_ok;
  logic [15:0] rx_len_type, cnt, nlast;
  logic [13:0] rx_frame_bytes;
  logic [2:0]  rx_dribble_bits;
  int          fail_count, compares, stops;

  ufc_top i_ufc_top (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .usb_wvalid(usb_wvalid),
    .usb_wdata(usb_wdata), .usb_wready(usb_wready), .usb_commit(usb_commit),
    .usb_rewind(usb_rewind), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
    .tx_ready(tx_ready), .rx_done(rx_done), .rx_late_col(rx_late_col),
    .rx_len_type(rx_len_type), .rx_frame_bytes(rx_frame_bytes), .rx_er_seen(rx_er_seen),
    .rx_dribble_bits(rx_dribble_bits), .rx_mode_10m(rx_mode_10m), .rx_crc_bad(rx_crc_bad),
    .rx_runt(rx_runt), .rx_too_long(rx_too_long), .rx_busy(rx_busy), .rx_wr_adv(rx_wr_adv),
    .rx_rd_adv(rx_rd_adv), .receiver_enable_bit(receiver_enable_bit),
    .receiver_stopped_event(receiver_stopped_event), .rx_frame_ok(rx_frame_ok),
    .rx_status_word(rx_status_word));
  ufc_link_sink i_ufc_link_sink (.clk(clk), .rstn(rstn), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last), .slow(slow), .tx_ready(tx_ready), .cnt(cnt),
    .nlast(nlast), .last_d(last_d), .last_l(last_l));

  always #5 clk = ~clk;
  always @(posedge clk) if (receiver_stopped_event === 1'b1) stops++;

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic results();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] dd);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= dd;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rdc(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task automatic wcnt(input logic [15:0] n);
    int i;
    for (i = 0; i < 300 && cnt !== n; i++) @(posedge clk);
    if (i == 300)
    begin
      fail_count++;
      $display("timeout waiting for link words");
      results();
    end
  endtask
  function automatic logic [31:0] ca(logic f, logic l, logic [1:0] o, logic [10:0] s);
    return {14'h0000, o, 2'h0, f, l, 1'h0, s};
  endfunction
  function automatic logic [31:0] cb(logic [10:0] len, logic ck);
    return {17'h00000, ck, 3'h0, len};
  endfunction
  task automatic pkt(input ufc_pkg::ufc_word_t w[$], input logic rew);
    int k;
    foreach (w[i])
    begin
      @(posedge clk);
      usb_wvalid <= 1'b1;
      usb_wdata  <= w[i];
      for (k = 0; k < 50; k++)
      begin
        @(negedge clk);
        if (usb_wready === 1'b1) break;
      end
      if (k == 50)
      begin
        fail_count++;
        $display("timeout waiting for write ready");
        results();
      end
    end
    @(posedge clk);
    usb_wvalid <= 1'b0;
    usb_commit <= !rew;
    usb_rewind <= rew;
    @(posedge clk);
    usb_commit <= 1'b0;
    usb_rewind <= 1'b0;
  endtask
  task automatic rxf(input logic lc, input logic [15:0] lt, input logic [13:0] b,
                     input logic er, input logic [2:0] dr, input logic m10,
                     input logic crc, input logic rn, input logic lg);
    logic w, dd, c;
    w  = b > 14'h0800;
    dd = !lc && (m10 ? dr >= 3'h3 : dr == 3'h4);
    c  = (crc || er) && !(rn || lc || w);
    @(posedge clk);
    {rx_late_col, rx_len_type, rx_frame_bytes, rx_er_seen} <= {lc, lt, b, er};
    {rx_dribble_bits, rx_mode_10m, rx_crc_bad, rx_runt, rx_too_long} <= {dr, m10, crc, rn, lg};
    rx_done <= 1'b1;
    @(posedge clk);
    rx_done <= 1'b0;
    #1 chk(rx_status_word, {2'h0, b, rn | lg | lc | c, 3'h0, rn, 3'h0, lg, lc,
                            lt > 16'h05dc && b >= 14'h000e, w, er, dd, c, 1'b0});
    chk({31'h0, rx_frame_ok}, {31'h0, !c});
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    clk = 1'b0;
    rstn = 1'b0;
    {reg_wr, reg_rd, usb_wvalid, usb_commit, usb_rewind, slow, rx_done, rx_busy} = '0;
    {rx_late_col, rx_er_seen, rx_mode_10m, rx_crc_bad, rx_runt, rx_too_long} = '0;
    {rx_wr_adv, rx_rd_adv, reg_addr, reg_wdata, usb_wdata, rx_dribble_bits} = '0;
    rx_len_type = 16'h0000;
    rx_frame_bytes = 14'h0000;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    rdc(4'h0, 32'h0000_0000);
    rdc(4'h4, 32'h0000_0002);
    wr(4'h2, 32'hffff_ffff);
    rdc(4'h2, 32'h0000_0000);
    rdc(4'h0, 32'h0000_0000);
    $display("test registers done");
    pkt('{ca(1, 1, 2'h0, 11'h004), cb(11'h004, 0), 32'h1111_1111}, 1'b1);
    pkt('{ca(1, 1, 2'h0, 11'h004), cb(11'h004, 0), 32'hdead_beef}, 1'b0);
    wcnt(16'h0001);
    repeat (5) @(posedge clk);
    chk({16'h0, cnt}, 32'h0000_0001);
    chk(last_d, 32'hdead_beef);
    chk({31'h0, last_l}, 32'h1);
    pkt('{ca(1, 1, 2'h2, 11'h004), cb(11'h004, 0), 32'haaaa_0000, 32'h0000_bbbb}, 1'b0);
    wcnt(16'h0003);
    chk(last_d, 32'h0000_bbbb);
    chk({16'h0, nlast}, 32'h0000_0002);
    slow <= 1'b1;
    pkt('{ca(1, 0, 2'h0, 11'h004), cb(11'h008, 0), 32'h0102_0304,
          ca(0, 1, 2'h0, 11'h004), cb(11'h008, 1), 32'h0506_0708}, 1'b0);
    wcnt(16'h0005);
    chk({16'h0, nlast}, 32'h0000_0003);
    chk(last_d, 32'h0506_0708);
    rdc(4'h4, 32'h0000_0002);
    slow <= 1'b0;
    pkt('{ca(1, 0, 2'h0, 11'h004), cb(11'h008, 0), 32'h0,
          ca(0, 1, 2'h0, 11'h004), cb(11'h009, 0), 32'h0}, 1'b0);
    wcnt(16'h0007);
    repeat (4) @(posedge clk);
    rdc(4'h4, 32'h0000_0003);
    rdc(4'h4, 32'h0000_0003);
    wr(4'h4, 32'h0000_0001);
    rdc(4'h4, 32'h0000_0002);
    pkt('{ca(1, 1, 2'h0, 11'h004), cb(11'h005, 0), 32'h0}, 1'b0);
    wcnt(16'h0008);
    repeat (4) @(posedge clk);
    rdc(4'h4, 32'h0000_0003);
    wr(4'h4, 32'h0000_0001);
    $display("test transmit done");
    rxf(1, 16'h0600, 14'd64, 0, 3'h4, 0, 1, 0, 0);
    rxf(0, 16'h05dc, 14'd100, 1, 3'h3, 0, 0, 0, 0);
    rxf(0, 16'h05dd, 14'd100, 0, 3'h4, 0, 0, 0, 0);
    rxf(0, 16'h0600, 14'd60, 0, 3'h3, 1, 0, 0, 0);
    rxf(0, 16'h0800, 14'd13, 0, 3'h0, 0, 1, 1, 0);
    rxf(0, 16'h0000, 14'd2049, 0, 3'h0, 0, 1, 0, 1);
    rxf(0, 16'h0000, 14'd2048, 0, 3'h0, 0, 1, 0, 0);
    rxf(0, 16'h0600, 14'd14, 0, 3'h2, 1, 0, 0, 0);
    $display("test receive status done");
    @(posedge clk);
    rx_wr_adv <= 1'b1;
    repeat (3) @(posedge clk);
    rx_wr_adv <= 1'b0;
    rx_rd_adv <= 1'b1;
    @(posedge clk);
    rx_rd_adv <= 1'b0;
    rdc(4'hc, 32'h0001_0003);
    wr(4'h0, 32'h0000_0001);
    rdc(4'h0, 32'h0000_0001);
    chk({31'h0, receiver_enable_bit}, 32'h1);
    @(posedge clk);
    rx_busy <= 1'b1;
    wr(4'h0, 32'h0000_0000);
    #1 chk({31'h0, receiver_enable_bit}, 32'h0);
    repeat (8) @(posedge clk);
    chk(stops, 32'h0);
    rx_busy <= 1'b0;
    repeat (10) @(posedge clk);
    chk(stops, 32'h1);
    rdc(4'h4, 32'h0000_0002);
    wr(4'h0, 32'h0000_0002);
    repeat (2) @(posedge clk);
    rdc(4'hc, 32'h0000_0000);
    rdc(4'h0, 32'h0000_0000);
    wr(4'h0, 32'h0000_0001);
    rdc(4'h0, 32'h0000_0001);
    $display("test stop and flush done");
    results();
  end
endmodule
